// ### pkg/rgf_map.svh
// Register offsets, field positions, reset values and decode constants of the receive control block.
`ifndef RGF_MAP_SVH
`define RGF_MAP_SVH

// Register addresses carried in the low four bits of a serial word.
`define RGF_ADDR_FILTER      4'h7
`define RGF_ADDR_SRC         4'h8
`define RGF_ADDR_SRC_SEL     4'h8
`define RGF_ADDR_GAIN        4'hB

// Serial word: fourteen data bits, most significant first, then four address bits.
`define RGF_DATA_W           14
`define RGF_WORD_BITS        5'h12

// Reset values of the stored registers.
`define RGF_RST_FILTER       14'h0002
`define RGF_RST_SRC          14'h0001
`define RGF_RST_GAIN         14'h0000

// Field positions.
`define RGF_GSRC_BIT         12
`define RGF_LNA_HI           6
`define RGF_LNA_LO           5
`define RGF_VGA_HI           4
`define RGF_VGA_LO           0
`define RGF_COARSE_HI        1
`define RGF_COARSE_LO        0
`define RGF_FINE_HI          2
`define RGF_FINE_LO          0
`define RGF_HPC_HI           13
`define RGF_HPC_LO           12

// Gain figures in dB, and the top VGA code.
`define RGF_LNA_MED_DB       6'h10
`define RGF_LNA_LOW_DB       6'h21
`define RGF_VGA_STEP_DB      6'h02
`define RGF_VGA_MAX_CODE     5'h1F

// Low-pass corners in kHz and trim percentages.
`define RGF_LPF_11B_KHZ      15'h1D4C
`define RGF_LPF_11G_KHZ      15'h2134
`define RGF_LPF_T1_KHZ       15'h3A98
`define RGF_LPF_T2_KHZ       15'h4650
`define RGF_TRIM_90          7'h5A
`define RGF_TRIM_95          7'h5F
`define RGF_TRIM_100         7'h64
`define RGF_TRIM_105         7'h69
`define RGF_TRIM_110         7'h6E

// Highpass corners in Hz.
`define RGF_HP_AC_HZ         20'h927C0
`define RGF_HP_100_HZ        20'h00064
`define RGF_HP_4K_HZ         20'h00FA0
`define RGF_HP_30K_HZ        20'h07530

`endif

// ### pkg/rgf_pkg.sv
// Types shared by the receive gain and filter control block.
package rgf_pkg;

  // Operating state, one-hot.
  typedef enum logic [3:0] {
    RGF_OFF   = 4'h1,
    RGF_RX    = 4'h2,
    RGF_TX    = 4'h4,
    RGF_TXCAL = 4'h8
  } rgf_mode_t;

  // What the receive baseband outputs carry.
  typedef enum logic [1:0] {
    RGF_BB_IDLE = 2'h0,
    RGF_BB_RX   = 2'h1,
    RGF_BB_DET  = 2'h2
  } rgf_bbsrc_t;

  typedef logic [13:0] rgf_word_t;

endpackage

// ### logic/rgf_serial_rx.sv
// Three-wire serial write receiver that delivers address and data words.
`timescale 1ns/10ps
`include "rgf_map.svh"
module rgf_serial_rx
  import rgf_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ser_cs_n_in,
  input  wire logic       ser_sclk_in,
  input  wire logic       ser_din_in,
  output logic            wr_stb_out,
  output logic [3:0]      wr_addr_out,
  output rgf_word_t       wr_data_out
);

  logic        sclk_q,  sclk_d;
  logic        cs_n_q,  cs_n_d;
  logic [17:0] shift_q, shift_d;
  logic [4:0]  cnt_q,   cnt_d;
  logic        stb_q,   stb_d;
  logic [3:0]  addr_q,  addr_d;
  rgf_word_t   data_q,  data_d;

  // Shift on each rising serial clock while selected; deliver on deselect only for a whole word.
  // A short or long frame is dropped so a glitch on the select line cannot corrupt a register.
  always_comb begin
    sclk_d  = ser_sclk_in;
    cs_n_d  = ser_cs_n_in;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    stb_d   = 1'b0;
    addr_d  = addr_q;
    data_d  = data_q;
    if (!ser_cs_n_in && ser_sclk_in && !sclk_q) begin
      shift_d = {shift_q[16:0], ser_din_in};
      if (cnt_q != 5'h1F) begin
        cnt_d = cnt_q + 5'h01;
      end
    end
    if (ser_cs_n_in && !cs_n_q) begin
      cnt_d = 5'h00;
      if (cnt_q == `RGF_WORD_BITS) begin
        stb_d  = 1'b1;
        addr_d = shift_q[3:0];
        data_d = shift_q[17:4];
      end
    end
  end

  // State registers.
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      shift_q <= 18'h00000;
      cnt_q   <= 5'h00;
      stb_q   <= 1'b0;
      addr_q  <= 4'h0;
      data_q  <= 14'h0000;
    end else begin
      sclk_q  <= sclk_d;
      cs_n_q  <= cs_n_d;
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      stb_q   <= stb_d;
      addr_q  <= addr_d;
      data_q  <= data_d;
    end
  end

  assign wr_stb_out  = stb_q;
  assign wr_addr_out = addr_q;
  assign wr_data_out = data_q;

endmodule

// ### logic/rgf_rx_control.sv
// Receive path control: operating state, gain source and decode, low-pass and highpass corner selection.
//
// Functional notes
// R1 - Receive enabled only when select low, awake.
// R2 - LNA code 11 max, 10 -16dB, 0x -33dB.
// R3 - LNA code from gain register or pins 7:6.
// R4 - Source register bit picks serial or pin gain.
// R5 - VGA has 62dB range, 2dB steps, five bits.
// R6 - VGA code bits binary weighted, 2dB to 32dB.
// R7 - All ones max gain, each decrement 2dB.
// R8 - Coarse corner from source register bits 1:0.
// R9 - Coarse codes: 7.5, 8.5, 15, 18 MHz.
// R10 - Coarse corner trimmed by filter register bits 2:0.
// R11 - Trim codes give 90 to 110 percent.
// R12 - Calibration routes detector to baseband outputs.
// R13 - Coupling pin high forces 600kHz AC coupling.
// R14 - Unselected gain source has no effect.
`timescale 1ns/10ps
`include "rgf_map.svh"
module rgf_rx_control
  import rgf_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       tx_rx_select_in,
  input  wire logic       power_down_n_in,
  input  wire logic       tx_cal_mode_in,
  input  wire logic       coupling_corner_select_in,
  input  wire logic       gain_pin_7_in,
  input  wire logic       gain_pin_6_in,
  input  wire logic       gain_pin_5_in,
  input  wire logic       gain_pin_4_in,
  input  wire logic       gain_pin_3_in,
  input  wire logic       gain_pin_2_in,
  input  wire logic       gain_pin_1_in,
  input  wire logic       ser_cs_n_in,
  input  wire logic       ser_sclk_in,
  input  wire logic       ser_din_in,
  output rgf_mode_t       mode_out,
  output logic            rx_path_en_out,
  output logic            gain_serial_sel_out,
  output logic [1:0]      lna_code_out,
  output logic [5:0]      lna_atten_db_out,
  output logic [4:0]      vga_code_out,
  output logic [5:0]      vga_atten_db_out,
  output logic [14:0]     lpf_coarse_khz_out,
  output logic [6:0]      lpf_trim_pct_out,
  output logic [14:0]     lpf_corner_khz_out,
  output logic            hp_ac_couple_out,
  output logic [19:0]     hp_corner_hz_out,
  output rgf_bbsrc_t      rx_inphase_out_p,
  output rgf_bbsrc_t      rx_quadrature_out_p
);

  // Serial write path.
  logic      wr_stb;
  logic [3:0] wr_addr;
  rgf_word_t wr_data;

  rgf_serial_rx u_serial (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .ser_cs_n_in (ser_cs_n_in),
    .ser_sclk_in (ser_sclk_in),
    .ser_din_in  (ser_din_in),
    .wr_stb_out  (wr_stb),
    .wr_addr_out (wr_addr),
    .wr_data_out (wr_data)
  );

  // Map a register address to its storage index; three means not held here.
  function automatic logic [1:0] reg_index(input logic [3:0] addr);
    case (addr)
      `RGF_ADDR_FILTER:  reg_index = 2'h0;
      `RGF_ADDR_SRC_SEL: reg_index = 2'h1;
      `RGF_ADDR_GAIN:    reg_index = 2'h2;
      default:           reg_index = 2'h3;
    endcase
  endfunction

  // Attenuation below maximum for an LNA code.
  function automatic logic [5:0] lna_atten(input logic [1:0] code);
    if (!code[1]) begin
      lna_atten = `RGF_LNA_LOW_DB; // R2
    end else if (!code[0]) begin
      lna_atten = `RGF_LNA_MED_DB; // R2
    end else begin
      lna_atten = 6'h00; // R2
    end
  endfunction

  // Attenuation below maximum for a VGA code; each count is one 2dB step.
  function automatic logic [5:0] vga_atten(input logic [4:0] code);
    logic [4:0] steps;
    steps     = `RGF_VGA_MAX_CODE - code;
    vga_atten = {steps, 1'b0}; // R6 R7
  endfunction

  // Stored write-only registers, reset to defined settings.
  rgf_word_t regs_q [0:2];
  rgf_word_t regs_d [0:2];
  localparam rgf_word_t RST_VAL [0:2] = '{`RGF_RST_FILTER, `RGF_RST_SRC, `RGF_RST_GAIN};

  // One identical write slot per register; unmapped addresses are dropped.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_reg
      always_comb begin
        regs_d[gi] = regs_q[gi];
        if (wr_stb && reg_index(wr_addr) == 2'(gi)) begin
          regs_d[gi] = wr_data;
        end
      end
      always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          regs_q[gi] <= RST_VAL[gi];
        end else begin
          regs_q[gi] <= regs_d[gi];
        end
      end
    end
  endgenerate

  // Operating state from the mode, shutdown and calibration inputs.
  rgf_mode_t mode_q, mode_d;

  always_comb begin
    case ({power_down_n_in, tx_rx_select_in})
      2'b10:   mode_d = RGF_RX; // R1
      2'b11:   mode_d = tx_cal_mode_in ? RGF_TXCAL : RGF_TX;
      default: mode_d = RGF_OFF;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_q <= RGF_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Gain decode. Only the selected source is looked at, so stray pin levels during serial
  // control cannot disturb the gain and stale register fields cannot leak into pin control.
  logic       gsel_q,  gsel_d;
  logic [1:0] lna_q,   lna_d;
  logic [5:0] lnadb_q, lnadb_d;
  logic [4:0] vga_q,   vga_d;
  logic [5:0] vgadb_q, vgadb_d;

  always_comb begin
    gsel_d = regs_q[1][`RGF_GSRC_BIT]; // R4
    if (gsel_d) begin
      lna_d = regs_q[2][`RGF_LNA_HI:`RGF_LNA_LO]; // R3 R14
      vga_d = regs_q[2][`RGF_VGA_HI:`RGF_VGA_LO]; // R5 R14
    end else begin
      lna_d = {gain_pin_7_in, gain_pin_6_in}; // R3 R14
      vga_d = {gain_pin_5_in, gain_pin_4_in, gain_pin_3_in, gain_pin_2_in, gain_pin_1_in}; // R5 R14
    end
    lnadb_d = lna_atten(lna_d); // R2
    vgadb_d = vga_atten(vga_d); // R5
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      gsel_q  <= 1'b0;
      lna_q   <= 2'h0;
      lnadb_q <= `RGF_LNA_LOW_DB;
      vga_q   <= 5'h00;
      vgadb_q <= 6'h3E;
    end else begin
      gsel_q  <= gsel_d;
      lna_q   <= lna_d;
      lnadb_q <= lnadb_d;
      vga_q   <= vga_d;
      vgadb_q <= vgadb_d;
    end
  end

  // Filter corners. Unused trim codes fall back to the untrimmed corner.
  logic [14:0] coarse_q, coarse_d;
  logic [6:0]  trim_q,   trim_d;
  logic [14:0] corner_q, corner_d;
  logic        hpac_q,   hpac_d;
  logic [19:0] hphz_q,   hphz_d;
  logic [31:0] prod;

  always_comb begin
    case (regs_q[1][`RGF_COARSE_HI:`RGF_COARSE_LO])
      2'h0:    coarse_d = `RGF_LPF_11B_KHZ; // R8 R9
      2'h1:    coarse_d = `RGF_LPF_11G_KHZ; // R9
      2'h2:    coarse_d = `RGF_LPF_T1_KHZ; // R9
      default: coarse_d = `RGF_LPF_T2_KHZ; // R9
    endcase
    case (regs_q[0][`RGF_FINE_HI:`RGF_FINE_LO])
      3'h0:    trim_d = `RGF_TRIM_90; // R10 R11
      3'h1:    trim_d = `RGF_TRIM_95; // R11
      3'h3:    trim_d = `RGF_TRIM_105; // R11
      3'h4:    trim_d = `RGF_TRIM_110; // R11
      default: trim_d = `RGF_TRIM_100; // R11
    endcase
    prod     = (32'(coarse_d) * 32'(trim_d)) / 32'd100;
    corner_d = prod[14:0]; // R10
    hpac_d   = coupling_corner_select_in; // R13
    if (coupling_corner_select_in) begin
      hphz_d = `RGF_HP_AC_HZ; // R13
    end else if (regs_q[0][`RGF_HPC_LO]) begin
      hphz_d = `RGF_HP_4K_HZ; // R13
    end else if (regs_q[0][`RGF_HPC_HI]) begin
      hphz_d = `RGF_HP_30K_HZ; // R13
    end else begin
      hphz_d = `RGF_HP_100_HZ; // R13
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      coarse_q <= `RGF_LPF_11G_KHZ;
      trim_q   <= `RGF_TRIM_100;
      corner_q <= `RGF_LPF_11G_KHZ;
      hpac_q   <= 1'b0;
      hphz_q   <= `RGF_HP_100_HZ;
    end else begin
      coarse_q <= coarse_d;
      trim_q   <= trim_d;
      corner_q <= corner_d;
      hpac_q   <= hpac_d;
      hphz_q   <= hphz_d;
    end
  end

  // Baseband output routing follows the next operating state so it stays aligned with mode_out.
  rgf_bbsrc_t bb_q, bb_d;

  always_comb begin
    case (mode_d)
      RGF_RX:    bb_d = RGF_BB_RX;
      RGF_TXCAL: bb_d = RGF_BB_DET; // R12
      default:   bb_d = RGF_BB_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bb_q <= RGF_BB_IDLE;
    end else begin
      bb_q <= bb_d;
    end
  end

  // Outputs straight from flip-flops.
  assign mode_out            = mode_q;
  assign rx_path_en_out      = mode_q[1];
  assign gain_serial_sel_out = gsel_q;
  assign lna_code_out        = lna_q;
  assign lna_atten_db_out    = lnadb_q;
  assign vga_code_out        = vga_q;
  assign vga_atten_db_out    = vgadb_q;
  assign lpf_coarse_khz_out  = coarse_q;
  assign lpf_trim_pct_out    = trim_q;
  assign lpf_corner_khz_out  = corner_q;
  assign hp_ac_couple_out    = hpac_q;
  assign hp_corner_hz_out    = hphz_q;
  assign rx_inphase_out_p    = bb_q;
  assign rx_quadrature_out_p = bb_q;

  // Check qualifier: low in reset and on the edge that leaves it, so checks that look one cycle
  // back never compare against a cycle in which the flops were still held in reset.
  logic chk_en_q, chk_en_d;

  always_comb begin
    chk_en_d = 1'b1;
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chk_en_q <= 1'b0;
    end else begin
      chk_en_q <= chk_en_d;
    end
  end

  // Checks.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in || !chk_en_q);

  sequence src_serial_write;
    wr_stb && reg_index(wr_addr) == 2'h1 && wr_data[`RGF_GSRC_BIT];
  endsequence

  sequence src_pin_write;
    wr_stb && reg_index(wr_addr) == 2'h1 && !wr_data[`RGF_GSRC_BIT];
  endsequence

  rx_enable_a: assert property (##1 rx_path_en_out == $past(!tx_rx_select_in && power_down_n_in)) // R1
    else $error("Receive enable does not follow mode and shutdown.");
  lna_low_a: assert property (!lna_code_out[1] |-> lna_atten_db_out == 6'h21) // R2
    else $error("Low LNA code does not give 33dB less.");
  lna_mid_a: assert property (lna_code_out == 2'h2 |-> lna_atten_db_out == 6'h10) // R2
    else $error("Medium LNA code does not give 16dB less.");
  lna_pin_a: assert property (##1 !$past(regs_q[1][12]) |-> lna_code_out == $past({gain_pin_7_in, gain_pin_6_in})) // R3
    else $error("LNA code not taken from pins.");
  src_serial_a: assert property (src_serial_write |-> ##2 gain_serial_sel_out) // R4
    else $error("Serial gain source not selected after write.");
  src_pin_a: assert property (src_pin_write |-> ##2 !gain_serial_sel_out) // R4
    else $error("Pin gain source not selected after write.");
  vga_step_a: assert property (vga_atten_db_out == 6'((5'h1F - vga_code_out) * 2)) // R5 R6 R7
    else $error("VGA attenuation not two dB per step.");
  vga_serial_a: assert property (##1 $past(regs_q[1][12]) |-> vga_code_out == $past(regs_q[2][4:0])) // R5
    else $error("VGA code not taken from register.");
  coarse_map_a: assert property (##1 $past(regs_q[1][1:0]) == 2'h3 |-> lpf_coarse_khz_out == 15'h4650) // R8 R9
    else $error("Coarse code three does not give 18MHz.");
  trim_map_a: assert property (##1 $past(regs_q[0][2:0]) == 3'h0 |-> lpf_trim_pct_out == 7'h5A) // R10 R11
    else $error("Trim code zero does not give 90 percent.");
  cal_route_a: assert property (mode_out == RGF_TXCAL |-> rx_inphase_out_p == RGF_BB_DET) // R12
    else $error("Calibration mode does not route detector.");
  hp_force_a: assert property (coupling_corner_select_in |=> hp_ac_couple_out && hp_corner_hz_out == 20'h927C0) // R13
    else $error("Coupling select does not force AC corner.");
  pin_ignore_a: assert property (gsel_q && regs_q[1][12] && $stable(regs_q[2]) |=> $stable(lna_code_out)) // R14
    else $error("Gain pins disturb serial gain.");

endmodule

// ### verification/rgf_bb_model.sv
// Behavioural baseband controller that writes the receive control registers over the serial lines.
`timescale 1ns/10ps
module rgf_bb_model (
  input  wire logic core_clk_in,
  output logic      ser_cs_n_out,
  output logic      ser_sclk_out,
  output logic      ser_din_out
);
  logic active;

  // Idle levels: deselected, clock resting low.
  initial begin
    ser_cs_n_out = 1'b1;
    ser_sclk_out = 1'b0;
    ser_din_out  = 1'b0;
    active       = 1'b0;
  end

  // Outside a frame the data line toggles each cycle, so a receiver that samples it there gets no stable value.
  always @(posedge core_clk_in) begin
    if (!active) begin
      ser_din_out <= ~ser_din_out;
    end
  end

  // Sends the leading bits of a word, most significant first; data is set while the clock is low.
  // A full word is fourteen data bits then four address bits, which is how the gain source bit is written.
  task automatic send(input logic [17:0] word, input int nbits);
    // The frame flag is raised on the clock edge, so it can never be cleared again by the
    // previous frame's closing assignment landing in the same time step.
    @(posedge core_clk_in);
    active       <= 1'b1;
    ser_cs_n_out <= 1'b0;
    for (int i = 17; i > 17 - nbits; i--) begin
      @(posedge core_clk_in) ser_din_out <= word[i];
      @(posedge core_clk_in) ser_sclk_out <= 1'b1;
      @(posedge core_clk_in) ser_sclk_out <= 1'b0;
    end
    @(posedge core_clk_in) ser_cs_n_out <= 1'b1;
    @(posedge core_clk_in) active <= 1'b0;
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking testbench of the receive gain and filter control block.
`timescale 1ns/10ps
`include "rgf_map.svh"
module testbench
  import rgf_pkg::*;
;
  logic        core_clk, sys_rst, tx_rx_sel, pdn_n, cal, cpl, rx_en, gsel, hp_ac;
  logic [6:0]  pins, trim;
  logic [31:0] seed;
  logic [13:0] filt_s, src_s, gain_s;
  logic [1:0]  lna;
  logic [5:0]  lna_db, vga_db;
  logic [4:0]  vga;
  logic [14:0] crs, crn;
  logic [19:0] hpz;
  logic [86:0] exp_q[$];
  int          n_mismatch, cmp_count, cyc;
  event        chk_ev;
  wire         cs_n, sclk, din;
  rgf_mode_t   mode;
  rgf_bbsrc_t  bb_i, bb_q;
  wire [86:0]  act = {mode, rx_en, gsel, lna, lna_db, vga, vga_db, crs, trim, crn, hp_ac, hpz, bb_i, bb_q};

  rgf_rx_control rgf_rx_control_i (.core_clk_in(core_clk), .sys_rst_in(sys_rst), .tx_rx_select_in(tx_rx_sel),
    .power_down_n_in(pdn_n), .tx_cal_mode_in(cal), .coupling_corner_select_in(cpl), .gain_pin_7_in(pins[6]),
    .gain_pin_6_in(pins[5]), .gain_pin_5_in(pins[4]), .gain_pin_4_in(pins[3]), .gain_pin_3_in(pins[2]),
    .gain_pin_2_in(pins[1]), .gain_pin_1_in(pins[0]), .ser_cs_n_in(cs_n), .ser_sclk_in(sclk), .ser_din_in(din),
    .mode_out(mode), .rx_path_en_out(rx_en), .gain_serial_sel_out(gsel), .lna_code_out(lna),
    .lna_atten_db_out(lna_db), .vga_code_out(vga), .vga_atten_db_out(vga_db), .lpf_coarse_khz_out(crs),
    .lpf_trim_pct_out(trim), .lpf_corner_khz_out(crn), .hp_ac_couple_out(hp_ac), .hp_corner_hz_out(hpz),
    .rx_inphase_out_p(bb_i), .rx_quadrature_out_p(bb_q));

  rgf_bb_model rgf_bb_model_i (.core_clk_in(core_clk), .ser_cs_n_out(cs_n), .ser_sclk_out(sclk),
    .ser_din_out(din));

  // Clock at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Expected outputs worked out from the shadow registers and the pin levels the bench drives.
  function automatic logic [86:0] expect_all();
    rgf_mode_t   m;
    rgf_bbsrc_t  b;
    logic [1:0]  l;
    logic [4:0]  v;
    logic [14:0] c;
    logic [6:0]  t;
    logic [31:0] p;
    logic [19:0] h;
    m = !pdn_n ? RGF_OFF : !tx_rx_sel ? RGF_RX : cal ? RGF_TXCAL : RGF_TX;
    b = (m == RGF_RX) ? RGF_BB_RX : (m == RGF_TXCAL) ? RGF_BB_DET : RGF_BB_IDLE;
    l = src_s[12] ? gain_s[6:5] : pins[6:5];
    v = src_s[12] ? gain_s[4:0] : pins[4:0];
    case (src_s[1:0])
      2'h0: c = `RGF_LPF_11B_KHZ;
      2'h1: c = `RGF_LPF_11G_KHZ;
      2'h2: c = `RGF_LPF_T1_KHZ;
      default: c = `RGF_LPF_T2_KHZ;
    endcase
    case (filt_s[2:0])
      3'h0: t = `RGF_TRIM_90;
      3'h1: t = `RGF_TRIM_95;
      3'h3: t = `RGF_TRIM_105;
      3'h4: t = `RGF_TRIM_110;
      default: t = `RGF_TRIM_100;
    endcase
    p = 32'(c) * 32'(t);
    h = cpl ? `RGF_HP_AC_HZ : filt_s[12] ? `RGF_HP_4K_HZ : filt_s[13] ? `RGF_HP_30K_HZ : `RGF_HP_100_HZ;
    return {m, m == RGF_RX, src_s[12], l, !l[1] ? `RGF_LNA_LOW_DB : l[0] ? 6'h00 : `RGF_LNA_MED_DB, v,
            6'((`RGF_VGA_MAX_CODE - v) * `RGF_VGA_STEP_DB), c, t, 15'(p / 100), cpl, h, b, b};
  endfunction

  // Next value of the xorshift sequence.
  function automatic void rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endfunction

  // Lets the outputs settle past the two-cycle serial answer, then queues the note for the monitor.
  task automatic check();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    exp_q.push_back(expect_all());
    ->chk_ev;
  endtask

  // Writes one register and tracks it; refused addresses leave the shadows alone.
  task automatic wr(input logic [3:0] addr, input logic [13:0] data);
    rgf_bb_model_i.send({data, addr}, 18);
    if (addr == `RGF_ADDR_FILTER) filt_s = data;
    if (addr == `RGF_ADDR_SRC_SEL) src_s = data;
    if (addr == `RGF_ADDR_GAIN) gain_s = data;
  endtask

  // Reset for three cycles; the shadows return to the stored reset values.
  task automatic do_reset();
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    filt_s = `RGF_RST_FILTER;
    src_s  = `RGF_RST_SRC;
    gain_s = `RGF_RST_GAIN;
  endtask

  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Monitor: takes the oldest note whenever a result is due and compares the whole output set.
  always @(chk_ev) begin
    logic [86:0] e;
    e = exp_q.pop_front();
    cmp_count++;
    if (act !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t expected=%h actual=%h", $time, e, act);
    end
  end

  // Cuts a hang short; the whole sequence needs some twelve hundred cycles.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    sys_rst = 1'b1;
    tx_rx_sel = 1'b0;
    pdn_n = 1'b0;
    cal = 1'b0;
    cpl = 1'b0;
    pins = 7'h00;
    seed = 32'h0000B9EF;
    do_reset();
    check();
    test_end("reset values");
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk) {cal, pdn_n, tx_rx_sel} <= 3'(i);
      check();
    end
    test_end("operating state");
    for (int i = 0; i < 12; i++) begin
      rnd();
      @(posedge core_clk) pins <= (i < 4) ? {2'(i), i[0] ? 5'h1F : 5'h00} : seed[6:0];
      check();
    end
    test_end("pin gain");
    rnd();
    wr(`RGF_ADDR_GAIN, seed[13:0]);
    check();
    for (int i = 0; i < 4; i++) begin
      wr(`RGF_ADDR_SRC_SEL, 14'h1000 | 14'(i));
      check();
    end
    for (int i = 0; i < 4; i++) begin
      rnd();
      @(posedge core_clk) pins <= seed[6:0];
      wr(`RGF_ADDR_GAIN, seed[20:7]);
      check();
    end
    test_end("serial gain");
    for (int i = 0; i < 8; i++) begin
      rnd();
      @(posedge core_clk) cpl <= seed[0];
      wr(`RGF_ADDR_FILTER, {2'(i), 9'h000, 3'(i)});
      check();
    end
    test_end("filter corners");
    wr(4'h3, 14'h3FFF);
    // A short frame whose last bits would decode as a source register write if its length were accepted.
    rgf_bb_model_i.send(18'h00010, 17);
    check();
    test_end("refused frames");
    do_reset();
    check();
    test_end("second reset");
    test_done();
  end
endmodule
